// File: rsm_unit.sv
/*
 single-cycle rotate / mask / shift datapath; result registered one edge
 after the request. assumes issue logic presents one decoded word per cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module rsm_unit (
   input wire logic sys_clk,
   input wire logic srst,
   input wire rsm_pkg::rsm_req_t req,
   output rsm_pkg::rsm_rsp_t rsp
);
   import rsm_pkg::*;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] rotl(input logic [31:0] v, input logic [4:0] n);
      logic [63:0] d;
      d = {v, v} << n;
      return d[63:32];
   endfunction

   // mask in msb numbering: position p maps to lsb index 31-p
   function automatic logic [31:0] mask_gen(input logic [4:0] mb, input logic [4:0] me);
      logic [31:0] m;
      m = WORD_ZERO;
      for (int p = 0; p < 32; p++) begin
         if (mb <= me) begin
            m[31-p] = (5'(p) >= mb) && (5'(p) <= me);
         end else begin
            m[31-p] = (5'(p) >= mb) || (5'(p) <= me);
         end
      end
      return m;
   endfunction

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire logic [5:0] opcd = req.instr[31:26];
   wire logic [4:0] sh_field = req.instr[15:11];
   wire logic [4:0] mask_begin = req.instr[10:6];
   wire logic [4:0] mask_stop = req.instr[5:1];
   wire logic [9:0] xo = req.instr[10:1];
   wire logic record_bit = req.instr[0];
   wire logic is_x = (opcd == OP_PRIMARY_X);
   wire logic is_rimm = (opcd == OP_ROT_IMM);
   wire logic is_rreg = (opcd == OP_ROT_REG);
   wire logic is_shl = is_x && (xo == XO_SHL);
   wire logic is_shr = is_x && (xo == XO_SHR);
   wire logic is_sar = is_x && (xo == XO_SAR);
   wire logic is_sari = is_x && (xo == XO_SARI);
   wire logic is_alg = is_sar || is_sari;
   wire logic hit = is_rimm || is_rreg || is_shl || is_shr || is_alg;
   wire logic amt_big = req.amount_gpr[AMT_BIG_BIT];

   // ------------------------------------------------------------
   // datapath
   // ------------------------------------------------------------
   // immediate forms take the field, register forms the low five bits
   wire logic [4:0] n = (is_rimm || is_sari) ? sh_field : req.amount_gpr[4:0];
   wire logic [4:0] neg_n = 5'(6'd32 - {1'b0, n});
   // rotate right n is rotate left 32-n; shifts reuse the rotator
   wire logic [31:0] rot_l = rotl(req.source_gpr, n);
   wire logic [31:0] rot_r = rotl(req.source_gpr, neg_n);
   wire logic [31:0] m_rot = mask_gen(mask_begin, mask_stop);
   wire logic [31:0] m_shl = amt_big ? WORD_ZERO : mask_gen(5'd0, 5'(5'd31 - n));
   wire logic [31:0] m_shr = (amt_big && !is_sari) ? WORD_ZERO : mask_gen(n, 5'd31);
   wire logic sgn = req.source_gpr[31];
   wire logic [31:0] res_rot = rot_l & m_rot;
   wire logic [31:0] res_shl = rot_l & m_shl;
   wire logic [31:0] res_shr = rot_r & m_shr;
   wire logic [31:0] res_alg = (rot_r & m_shr) | ({32{sgn}} & ~m_shr);
   // ones that fall off the right; zero amount gives no bits out
   wire logic ca = sgn && ((rot_r & ~m_shr) != WORD_ZERO);
   wire logic [31:0] result = (is_rimm || is_rreg) ? res_rot :
                              is_shl ? res_shl :
                              is_shr ? res_shr : res_alg;
   wire logic [3:0] cr_val = {$signed(result) < 0, $signed(result) > 0,
                              result == WORD_ZERO, req.sticky_ovf};

   // ------------------------------------------------------------
   // output register
   // ------------------------------------------------------------
   rsm_rsp_t rsp_nxt;
   always_comb begin
      rsp_nxt.valid = req.valid && hit;
      rsp_nxt.wr_dest = req.valid && hit;
      rsp_nxt.dest_gpr = hit ? result : WORD_ZERO;
      rsp_nxt.wr_ca = req.valid && is_alg;
      rsp_nxt.shift_out_flag = is_alg && ca;
      rsp_nxt.wr_cr0 = req.valid && hit && record_bit;
      rsp_nxt.condition_field_zero = hit ? cr_val : CR_RESET;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rsp <= '0;
      end else begin
         rsp <= rsp_nxt;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   // references built apart from the rotator and mask generator, so the
   // checks that use them do not just repeat the datapath expressions
   wire logic [4:0] reg_amt = req.amount_gpr[4:0];
   wire logic [31:0] rot_by_reg = (req.source_gpr << reg_amt) |
                                  (req.source_gpr >> (6'd32 - {1'b0, reg_amt}));
   wire logic [31:0] rot_by_imm = (req.source_gpr << sh_field) |
                                  (req.source_gpr >> (6'd32 - {1'b0, sh_field}));
   wire logic [4:0] back_amt = 5'(6'd32 - {1'b0, sh_field});
   wire logic [31:0] rotr_ref = (req.source_gpr >> back_amt) |
                                (req.source_gpr << (6'd32 - {1'b0, back_amt}));
   wire logic [31:0] lo_part = 32'hffff_ffff >> mask_begin;
   wire logic [31:0] hi_part = 32'hffff_ffff << (5'd31 - mask_stop);
   wire logic [31:0] ref_mask = (mask_begin <= mask_stop) ? (lo_part & hi_part) :
                                (lo_part | hi_part);
   // a big register amount pushes every source bit out
   wire logic [5:0] lost_amt = (is_sar && amt_big) ? 6'd32 : {1'b0, n};
   wire logic [31:0] lost_bits = req.source_gpr & ~(32'hffff_ffff << lost_amt);

   property p_shl_big;
      @(posedge sys_clk) disable iff (srst)
         (req.valid && is_shl && amt_big) |=> (rsp.wr_dest && rsp.dest_gpr == 32'h0);
   endproperty
   a_shl_big: assert property (p_shl_big) else $error("shift left big not zero");

   property p_shr_big;
      @(posedge sys_clk) disable iff (srst)
         (req.valid && is_shr && amt_big) |=> (rsp.dest_gpr == 32'h0);
   endproperty
   a_shr_big: assert property (p_shr_big) else $error("shift right big not zero");

   property p_sar_big;
      @(posedge sys_clk) disable iff (srst)
         (req.valid && is_sar && amt_big) |=> (rsp.dest_gpr == {32{$past(req.source_gpr[31])}});
   endproperty
   a_sar_big: assert property (p_sar_big) else $error("sign fill wrong");

   property p_zero_amt;
      @(posedge sys_clk) disable iff (srst)
         (req.valid && is_alg && n == 5'd0 && !(is_sar && amt_big))
         |=> (!rsp.shift_out_flag && rsp.dest_gpr == $past(req.source_gpr));
   endproperty
   a_zero_amt: assert property (p_zero_amt) else $error("zero shift altered");

   property p_ca_pos;
      @(posedge sys_clk) disable iff (srst)
         (req.valid && is_alg && !req.source_gpr[31]) |=> !rsp.shift_out_flag;
   endproperty
   a_ca_pos: assert property (p_ca_pos) else $error("carry on positive");

   property p_shl_val;
      @(posedge sys_clk) disable iff (srst)
         (req.valid && is_shl && !amt_big)
         |=> (rsp.dest_gpr == ($past(req.source_gpr) << $past(n)));
   endproperty
   a_shl_val: assert property (p_shl_val) else $error("shift left value");

   property p_shr_val;
      @(posedge sys_clk) disable iff (srst)
         (req.valid && is_shr && !amt_big)
         |=> (rsp.dest_gpr == ($past(req.source_gpr) >> $past(n)));
   endproperty
   a_shr_val: assert property (p_shr_val) else $error("shift right value");

   property p_sari_val;
      @(posedge sys_clk) disable iff (srst)
         (req.valid && is_sari)
         |=> (rsp.dest_gpr == 32'($signed($past(req.source_gpr)) >>> $past(n)));
   endproperty
   a_sari_val: assert property (p_sari_val) else $error("immediate sign shift");

   property p_rotate_full;
      @(posedge sys_clk) disable iff (srst)
         (req.valid && is_rreg && mask_begin == 5'd0 && mask_stop == 5'd31)
         |=> (rsp.dest_gpr == rotl($past(req.source_gpr), $past(req.amount_gpr[4:0])));
   endproperty
   a_rotate_full: assert property (p_rotate_full) else $error("rotate wrong");

   sequence s_rec_req;
      req.valid && hit && record_bit;
   endsequence
   property p_record;
      @(posedge sys_clk) disable iff (srst)
         s_rec_req |=> (rsp.wr_cr0 && rsp.condition_field_zero[1] == (rsp.dest_gpr == 32'h0));
   endproperty
   a_record: assert property (p_record) else $error("cr0 update wrong");

   property p_sar_decode;
      @(posedge sys_clk) disable iff (srst)
         (req.valid && opcd == 6'h1f && xo == 10'h318) |=> rsp.wr_ca;
   endproperty
   a_sar_decode: assert property (p_sar_decode) else $error("decode miss");

   property p_rimm_val;
      @(posedge sys_clk) disable iff (srst)
         (req.valid && is_rimm && mask_begin <= mask_stop)
         |=> (rsp.dest_gpr == $past(rot_by_imm & ref_mask));
   endproperty
   a_rimm_val: assert property (p_rimm_val) else $error("immediate rotate value");

   property p_rreg_val;
      @(posedge sys_clk) disable iff (srst)
         (req.valid && is_rreg && mask_begin <= mask_stop)
         |=> (rsp.dest_gpr == $past(rot_by_reg & ref_mask));
   endproperty
   a_rreg_val: assert property (p_rreg_val) else $error("register rotate value");

   sequence s_rot_wrapped;
      req.valid && (is_rimm || is_rreg) && (mask_begin > mask_stop);
   endsequence
   property p_mask_wrap;
      @(posedge sys_clk) disable iff (srst)
         s_rot_wrapped
         |=> (rsp.dest_gpr == $past((is_rreg ? rot_by_reg : rot_by_imm) & ref_mask));
   endproperty
   a_mask_wrap: assert property (p_mask_wrap) else $error("wrapped mask");

   sequence s_rot_req;
      req.valid && (is_rimm || is_rreg);
   endsequence
   property p_mask_outside;
      @(posedge sys_clk) disable iff (srst)
         s_rot_req |=> ((rsp.dest_gpr & ~$past(ref_mask)) == 32'h0);
   endproperty
   a_mask_outside: assert property (p_mask_outside) else $error("mask leak");

   property p_rotr;
      @(posedge sys_clk) disable iff (srst)
         (req.valid && is_rimm && mask_begin == 5'd0 && mask_stop == 5'd31)
         |=> (rsp.dest_gpr == $past(rotr_ref));
   endproperty
   a_rotr: assert property (p_rotr) else $error("rotate right form");

   property p_clear_left;
      @(posedge sys_clk) disable iff (srst)
         (req.valid && is_rimm && sh_field == 5'd0 && mask_stop == 5'd31)
         |=> (rsp.dest_gpr == $past(req.source_gpr & (32'hffff_ffff >> mask_begin)));
   endproperty
   a_clear_left: assert property (p_clear_left) else $error("clear left form");

   property p_sar_val;
      @(posedge sys_clk) disable iff (srst)
         (req.valid && is_sar && !amt_big)
         |=> (rsp.dest_gpr == 32'($signed($past(req.source_gpr)) >>> $past(reg_amt)));
   endproperty
   a_sar_val: assert property (p_sar_val) else $error("register sign shift");

   sequence s_alg_req;
      req.valid && is_alg;
   endsequence
   property p_ca_val;
      @(posedge sys_clk) disable iff (srst)
         s_alg_req
         |=> (rsp.wr_ca && rsp.shift_out_flag == $past(req.source_gpr[31] && lost_bits != 32'h0));
   endproperty
   a_ca_val: assert property (p_ca_val) else $error("carry value");

   property p_record_sign;
      @(posedge sys_clk) disable iff (srst)
         s_rec_req
         |=> (rsp.condition_field_zero[3] == rsp.dest_gpr[31]
              && rsp.condition_field_zero[2] == (!rsp.dest_gpr[31] && rsp.dest_gpr != 32'h0));
   endproperty
   a_record_sign: assert property (p_record_sign) else $error("cr0 sign bits");

   property p_record_so;
      @(posedge sys_clk) disable iff (srst)
         s_rec_req |=> (rsp.condition_field_zero[0] == $past(req.sticky_ovf));
   endproperty
   a_record_so: assert property (p_record_so) else $error("cr0 sticky bit");

   sequence s_plain_req;
      req.valid && hit && !record_bit;
   endsequence
   property p_no_record;
      @(posedge sys_clk) disable iff (srst)
         s_plain_req |=> !rsp.wr_cr0;
   endproperty
   a_no_record: assert property (p_no_record) else $error("cr0 written");

   property p_refused;
      @(posedge sys_clk) disable iff (srst)
         (req.valid && !hit)
         |=> (!rsp.valid && !rsp.wr_dest && !rsp.wr_ca && !rsp.wr_cr0 && rsp.dest_gpr == 32'h0);
   endproperty
   a_refused: assert property (p_refused) else $error("unknown op answered");

   property p_result_written;
      @(posedge sys_clk) disable iff (srst)
         (req.valid && hit) |=> (rsp.valid && rsp.wr_dest);
   endproperty
   a_result_written: assert property (p_result_written) else $error("no write");
endmodule // rsm_unit
`default_nettype wire

// File: rsm_pkg.sv
/*
 package for the rotate, mask and shift unit: opcodes, field positions,
 carrier structs. assumes big-endian bit numbering (bit 0 = msb) in the isa.
*/
package rsm_pkg;
   localparam logic [5:0] OP_PRIMARY_X = 6'h1f;
   localparam logic [5:0] OP_ROT_IMM = 6'h15;
   localparam logic [5:0] OP_ROT_REG = 6'h17;
   localparam logic [9:0] XO_SHL = 10'h018;
   localparam logic [9:0] XO_SHR = 10'h218;
   localparam logic [9:0] XO_SAR = 10'h318;
   localparam logic [9:0] XO_SARI = 10'h338;
   // msb-numbered bit 26 of the amount register is lsb-numbered bit 5
   localparam int AMT_BIG_BIT = 5;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [3:0] CR_RESET = 4'h0;

   typedef struct packed {
      logic valid;
      logic [31:0] instr;
      logic [31:0] source_gpr;
      logic [31:0] amount_gpr;
      logic sticky_ovf;
   } rsm_req_t;

   typedef struct packed {
      logic valid;
      logic wr_dest;
      logic [31:0] dest_gpr;
      logic wr_ca;
      logic shift_out_flag;
      logic wr_cr0;
      logic [3:0] condition_field_zero;
   } rsm_rsp_t;
endpackage

// File: rsm_issue_model.sv
/*
 issue-stage model: registers one request per go pulse.
 assumes the bench supplies sys_clk and the synchronous srst.
*/
`timescale 1ns/1ps
`default_nettype none
module rsm_issue_model (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic go,
   input wire logic [31:0] ins,
   input wire logic [31:0] src,
   input wire logic [31:0] amt,
   input wire logic so,
   output rsm_pkg::rsm_req_t req
);
   import rsm_pkg::*;
   // idle cycles show inverted operands so stale data is never mistaken for valid
   always_ff @(posedge sys_clk) begin
      if (srst)
         req <= '0;
      else if (go)
         req <= {1'b1, ins, src, amt, so};
      else
         req <= {1'b0, ~req.instr, ~req.source_gpr, ~req.amount_gpr, ~req.sticky_ovf};
   end
endmodule // rsm_issue_model
`default_nettype wire

// File: rsm_unit_tb.sv
/*
 self-checking bench for the rotate, mask and shift unit.
 assumes the issue model adds one cycle ahead of the unit.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
   $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module rsm_unit_tb;
   import rsm_pkg::*;
   localparam logic [31:0] RS = 32'h8421_f00d;
   logic sys_clk = 1'b0, srst = 1'b1, go = 1'b0, so = 1'b0;
   logic [31:0] ins = '0, src = '0, amt = '0;
   rsm_req_t req;
   rsm_rsp_t rsp;
   int miscompares = 0, num_checks = 0;
   always #20 sys_clk = ~sys_clk;
   rsm_issue_model rsm_issue_model_i (.sys_clk(sys_clk), .srst(srst), .go(go), .ins(ins),
      .src(src), .amt(amt), .so(so), .req(req));
   rsm_unit rsm_unit_i (.sys_clk(sys_clk), .srst(srst), .req(req), .rsp(rsp));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] xf(logic [9:0] xo, logic [4:0] sh, logic rc);
      return {OP_PRIMARY_X, 10'h000, sh, xo, rc};
   endfunction
   function automatic logic [31:0] rf(logic [5:0] op, logic [4:0] sh, mb, me, logic rc);
      return {op, 10'h000, sh, mb, me, rc};
   endfunction
   // msb-numbered positions, wrapping when begin is above stop
   function automatic logic [31:0] msk(int b, int e);
      logic [31:0] m;
      for (int k = 0; k < 32; k++) m[31-k] = (b <= e) ? (k >= b && k <= e) : (k >= b || k <= e);
      return m;
   endfunction
   task automatic issue(input logic [31:0] i, s, a, input logic o);
      @(posedge sys_clk);
      go <= 1'b1;
      ins <= i;
      src <= s;
      amt <= a;
      so <= o;
      @(posedge sys_clk);
      go <= 1'b0;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic expect_rsp(input logic [31:0] d, input logic wca, ca);
      `CHK(rsp.valid, 1'b1);
      `CHK(rsp.wr_dest, 1'b1);
      `CHK(rsp.dest_gpr, d);
      `CHK(rsp.wr_ca, wca);
      `CHK(rsp.wr_cr0, 1'b0);
      if (wca) `CHK(rsp.shift_out_flag, ca);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_rot;
      issue(rf(OP_ROT_IMM, 5'h04, 5'h00, 5'h1f, 1'b0), RS, 32'h0000_0000, 1'b0);
      expect_rsp({RS[27:0], RS[31:28]}, 1'b0, 1'b0);
      issue(rf(OP_ROT_REG, 5'h00, 5'h1c, 5'h03, 1'b0), RS, 32'hffff_ffe4, 1'b0);
      expect_rsp({RS[27:0], RS[31:28]} & msk(28, 3), 1'b0, 1'b0);
      issue(rf(OP_ROT_IMM, 5'h1c, 5'h00, 5'h1f, 1'b0), RS, 32'h0000_0000, 1'b0);
      expect_rsp({RS[3:0], RS[31:4]}, 1'b0, 1'b0);
      issue(rf(OP_ROT_IMM, 5'h00, 5'h08, 5'h1f, 1'b0), RS, 32'h0000_0000, 1'b0);
      expect_rsp(RS & 32'h00ff_ffff, 1'b0, 1'b0);
   endtask
   task automatic t_shift_sar;
      logic [31:0] a [5] = '{32'h0, 32'h4, 32'h1f, 32'h20, 32'h3f};
      logic [31:0] s [3] = '{RS, 32'h0000_00f0, 32'h8000_0010};
      int n;
      for (int k = 0; k < 5; k++) begin
         issue(xf(XO_SHL, 5'h00, 1'b0), RS, a[k], 1'b0);
         expect_rsp(a[k][5] ? WORD_ZERO : RS << a[k][4:0], 1'b0, 1'b0);
         issue(xf(XO_SHR, 5'h00, 1'b0), RS, a[k], 1'b0);
         expect_rsp(a[k][5] ? WORD_ZERO : RS >> a[k][4:0], 1'b0, 1'b0);
         for (int j = 0; j < 3; j++) begin
            n = a[k][5] ? 32 : int'(a[k][4:0]);
            issue(xf(XO_SAR, 5'h00, 1'b0), s[j], a[k], 1'b0);
            expect_rsp($signed(s[j]) >>> n, 1'b1,
               s[j][31] & |(s[j] & ~(32'hffff_ffff << n)));
            n = int'(a[k][4:0]);
            issue(xf(XO_SARI, a[k][4:0], 1'b0), s[j], 32'hffff_ffff, 1'b0);
            expect_rsp($signed(s[j]) >>> n, 1'b1,
               s[j][31] & |(s[j] & ~(32'hffff_ffff << n)));
         end
      end
   endtask
   task automatic t_record;
      logic [31:0] s [3] = '{32'h8000_0000, 32'h8000_0000, 32'h0000_0001};
      logic [31:0] a [3] = '{32'h0, 32'h20, 32'h1};
      logic [3:0] cr [3] = '{4'h9, 4'h3, 4'h5};
      for (int k = 0; k < 3; k++) begin
         issue(xf(XO_SHL, 5'h00, 1'b1), s[k], a[k], 1'b1);
         `CHK(rsp.wr_cr0, 1'b1);
         `CHK(rsp.condition_field_zero, cr[k]);
      end
   endtask
   task automatic t_refused;
      issue(rf(6'h3f, 5'h04, 5'h00, 5'h1f, 1'b1), RS, 32'h0000_0004, 1'b0);
      `CHK(rsp, rsm_rsp_t'(0));
      issue(xf(10'h319, 5'h00, 1'b0), RS, 32'h0000_0004, 1'b0);
      `CHK(rsp.valid, 1'b0);
   endtask
   task automatic report_and_stop;
      if (miscompares == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // a hung run counts as a miscompare
   initial begin
      #100us;
      miscompares++;
      report_and_stop;
   end
   initial begin
      repeat (12) @(posedge sys_clk);
      `CHK(rsp, rsm_rsp_t'(0));
      srst <= 1'b0;
      t_rot;
      t_shift_sar;
      t_record;
      t_refused;
      report_and_stop;
   end
endmodule // rsm_unit_tb
`default_nettype wire
